/* address_breakpoint_unit.sv */
// Address breakpoint unit: compares program fetches with a break address,
// substitutes the software interrupt opcode and supplies the break vector.
// Assumes the CPU flags fetch cycles and takes o_ir_data one cycle later.
`timescale 1ns/1ps

module address_breakpoint_unit
    import breakpoint_pkg::*;
#(
    parameter logic [7:0] SOFTWARE_INTERRUPT_OPCODE    = 8'h01,
    parameter logic [7:0] RETURN_FROM_INTERRUPT_OPCODE = 8'h02
) (
    // Clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    // CPU bus
    input  wire logic [ADDR_W-1:0] i_cpu_addr,
    input  wire logic              i_cpu_fetch,
    input  wire logic              i_opcode_fetch,
    input  wire logic [DATA_W-1:0] i_fetch_data,
    input  wire logic              i_vector_low,
    input  wire logic              i_monitor_mode,
    // Software writes of the break settings
    input  wire logic              i_wr_break_address_high,
    input  wire logic              i_wr_break_address_low,
    input  wire logic              i_wr_control,
    input  wire logic [DATA_W-1:0] i_wr_data,
    // Watchdog test qualifier
    input  wire logic              i_watchdog_test,
    // To CPU and system integration unit
    output logic [DATA_W-1:0]      o_ir_data,
    output logic                   o_ir_valid,
    output logic [ADDR_W-1:0]      o_vector_addr,
    output logic                   o_breakpoint_request,
    output logic                   o_in_break,
    output logic                   o_io_access_enable,
    output logic                   o_watchdog_disable,
    // Readback of the break settings
    output logic [ADDR_W-1:0]      o_break_address,
    output logic                   o_break_enable_flag,
    output logic                   o_break_active_flag
);
    // Equal opcodes would make every injected break look like its own return
    if (SOFTWARE_INTERRUPT_OPCODE == RETURN_FROM_INTERRUPT_OPCODE) begin : g_opcode_check
        $error("interrupt and return opcodes must differ");
    end

    address_compare_if cmp_bus ();

    break_state_e state_q;
    break_state_e state_d;
    logic [7:0]   break_address_high_q;
    logic [7:0]   break_address_low_q;
    logic         enable_q;
    logic         active_q;

    wire match;
    wire software_trigger;
    wire inject;
    wire return_seen;
    wire active_d;
    wire [15:0] vector_base;
    wire [15:0] vector_d;

    assign cmp_bus.clk        = i_mclk;
    assign cmp_bus.rst        = i_rst;
    assign cmp_bus.cpu_addr   = i_cpu_addr;
    assign cmp_bus.cpu_fetch  = i_cpu_fetch;
    assign cmp_bus.break_addr = {break_address_high_q, break_address_low_q};
    assign cmp_bus.enable     = enable_q;
    // No new address break while the break routine itself runs
    assign cmp_bus.blocked    = (state_q == ST_BREAK);

    address_match_unit u_match (
        .bus (cmp_bus.cmp)
    );

    assign match            = cmp_bus.match;
    assign software_trigger = i_wr_control && i_wr_data[ACTIVE_FLAG_BIT];
    // Opcode match swaps the opcode itself; pending breaks wait for the next opcode
    assign inject           = i_opcode_fetch && (state_q != ST_BREAK)
                              && ((state_q == ST_PENDING) || match);
    assign return_seen      = (state_q == ST_BREAK) && i_opcode_fetch
                              && (i_fetch_data == RETURN_FROM_INTERRUPT_OPCODE);
    // Hardware set wins over a software clear in the same cycle
    assign active_d         = match ? 1'b1
                              : (i_wr_control ? i_wr_data[ACTIVE_FLAG_BIT] : active_q);
    assign vector_base      = i_monitor_mode ? VECTOR_MONITOR : VECTOR_NORMAL;
    assign vector_d         = i_vector_low ? (vector_base | VECTOR_LOW_OFFSET) : vector_base;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (inject) begin
                    state_d = ST_BREAK;
                end else if (match || software_trigger) begin
                    state_d = ST_PENDING;
                end
            end
            ST_PENDING: begin
                if (inject) begin
                    state_d = ST_BREAK;
                end
            end
            ST_BREAK: begin
                if (return_seen) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_q              <= ST_IDLE;
            break_address_high_q <= ADDR_BYTE_RESET;
            break_address_low_q  <= ADDR_BYTE_RESET;
            enable_q             <= FLAG_RESET;
            active_q             <= FLAG_RESET;
        end else begin
            state_q  <= state_d;
            active_q <= active_d;
            if (i_wr_break_address_high) begin
                break_address_high_q <= i_wr_data;
            end
            if (i_wr_break_address_low) begin
                break_address_low_q <= i_wr_data;
            end
            if (i_wr_control) begin
                enable_q <= i_wr_data[ENABLE_FLAG_BIT];
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_ir_data            <= 8'h00;
            o_ir_valid           <= 1'b0;
            o_vector_addr        <= VECTOR_NORMAL;
            o_breakpoint_request <= 1'b0;
            o_in_break           <= 1'b0;
            o_io_access_enable   <= 1'b0;
            o_watchdog_disable   <= 1'b0;
        end else begin
            o_ir_data            <= inject ? SOFTWARE_INTERRUPT_OPCODE : i_fetch_data;
            o_ir_valid           <= i_opcode_fetch;
            o_vector_addr        <= vector_d;
            o_breakpoint_request <= match || software_trigger;
            o_in_break           <= (state_d == ST_BREAK);
            // The break does not gate peripheral access, so it stays open throughout
            o_io_access_enable   <= 1'b1;
            o_watchdog_disable   <= (state_d == ST_BREAK) && i_watchdog_test;
        end
    end

    assign o_break_address     = {break_address_high_q, break_address_low_q};
    assign o_break_enable_flag = enable_q;
    assign o_break_active_flag = active_q;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    a_match_sets_active: assert property (match |=> o_break_active_flag)
        else $error("match did not set the active flag");
    a_match_requests: assert property (match |=> o_breakpoint_request)
        else $error("match did not raise the breakpoint request");
    a_request_cause: assert property (o_breakpoint_request
        |-> $past(match) || $past(software_trigger))
        else $error("breakpoint request without a match or trigger");
    a_disabled_no_req: assert property (!enable_q && !software_trigger
        |=> !o_breakpoint_request)
        else $error("request while breaks disabled");
    a_opcode_swap: assert property (match && i_opcode_fetch
        |=> o_ir_valid && (o_ir_data == SOFTWARE_INTERRUPT_OPCODE) && o_in_break)
        else $error("opcode match did not inject the interrupt opcode");
    a_operand_defer: assert property ((state_q == ST_IDLE)
        && match && !i_opcode_fetch |=> (state_q == ST_PENDING) && !o_in_break)
        else $error("operand match did not defer the break");
    a_pending_inject: assert property ((state_q == ST_PENDING) && i_opcode_fetch
        |=> o_in_break && (o_ir_data == SOFTWARE_INTERRUPT_OPCODE))
        else $error("pending break did not take the next opcode");
    a_soft_trigger: assert property ((state_q == ST_IDLE)
        && software_trigger && !inject ##1 (!i_opcode_fetch [*1]) ##1 i_opcode_fetch
        |=> (o_ir_data == SOFTWARE_INTERRUPT_OPCODE))
        else $error("software trigger did not force the interrupt opcode");
    a_soft_clear: assert property (i_wr_control && !match
        && !i_wr_data[ACTIVE_FLAG_BIT] |=> !o_break_active_flag)
        else $error("software clear of the active flag lost");
    a_vector_monitor: assert property (i_monitor_mode && !i_vector_low
        |=> (o_vector_addr == VECTOR_MONITOR))
        else $error("wrong monitor break vector");
    a_vector_mon_low: assert property (i_monitor_mode && i_vector_low
        |=> (o_vector_addr == (VECTOR_MONITOR | VECTOR_LOW_OFFSET)))
        else $error("wrong monitor low break vector");
    a_vector_normal: assert property (!i_monitor_mode && i_vector_low
        |=> (o_vector_addr == (VECTOR_NORMAL | VECTOR_LOW_OFFSET)))
        else $error("wrong normal break vector");
    a_vector_norm_high: assert property (!i_monitor_mode && !i_vector_low
        |=> (o_vector_addr == VECTOR_NORMAL))
        else $error("wrong normal high break vector");
    a_return_ends: assert property (return_seen
        |=> !o_in_break ##1 (!o_in_break || $past(inject)))
        else $error("return did not end the break state");
    a_break_holds: assert property ((state_q == ST_BREAK) && !return_seen
        |=> o_in_break)
        else $error("break state left without a return");
    a_watchdog_off: assert property (o_watchdog_disable
        |-> o_in_break && $past(i_watchdog_test))
        else $error("watchdog disabled outside a break");
    a_io_open: assert property (o_in_break |-> o_io_access_enable)
        else $error("peripheral access closed during break");
endmodule

/* address_breakpoint_unit_bench.sv */
// Self-checking bench: a reference model is compared with the unit every cycle after reset, and once at the end of each reset.
// Assumes the CPU model drives fetches while the bench drives writes.
`timescale 1ns/1ps
module address_breakpoint_unit_bench import breakpoint_pkg::*;;
    localparam logic [7:0] INT_OP = 8'h01;
    localparam logic [7:0] RET_OP = 8'h02;
    logic        i_mclk, i_rst, i_vector_low, i_monitor_mode, i_watchdog_test;
    logic        i_wr_break_address_high, i_wr_break_address_low, i_wr_control;
    logic        i_cpu_fetch, i_opcode_fetch, o_ir_valid, o_breakpoint_request, o_in_break;
    logic        o_io_access_enable, o_watchdog_disable, o_break_enable_flag;
    logic        o_break_active_flag;
    logic [7:0]  i_wr_data, i_fetch_data, o_ir_data;
    logic [15:0] i_cpu_addr, o_vector_addr, o_break_address, t;
    logic [31:0] r;
    int          err_total, n_compared, seed, ba, en, act, breakpoint_unit, pend, req, vld, ir, vec;
    int          io, wdg;

    address_breakpoint_unit #(.SOFTWARE_INTERRUPT_OPCODE(INT_OP),
        .RETURN_FROM_INTERRUPT_OPCODE(RET_OP)) dut (.i_mclk, .i_rst, .i_cpu_addr,
        .i_cpu_fetch, .i_opcode_fetch, .i_fetch_data, .i_vector_low, .i_monitor_mode,
        .i_wr_break_address_high, .i_wr_break_address_low, .i_wr_control, .i_wr_data,
        .i_watchdog_test, .o_ir_data, .o_ir_valid, .o_vector_addr, .o_breakpoint_request,
        .o_in_break, .o_io_access_enable, .o_watchdog_disable, .o_break_address,
        .o_break_enable_flag, .o_break_active_flag);
    cpu_fetch_model cpu (.o_addr(i_cpu_addr), .o_fetch(i_cpu_fetch),
        .o_opcode(i_opcode_fetch), .o_data(i_fetch_data));

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cmp();
        chk("request", 16'(o_breakpoint_request), 16'(req));
        chk("in_break", 16'(o_in_break), 16'(breakpoint_unit));
        chk("active", 16'(o_break_active_flag), 16'(act));
        chk("enable", 16'(o_break_enable_flag), 16'(en));
        chk("brk_addr", o_break_address, 16'(ba));
        chk("vector", o_vector_addr, 16'(vec));
        chk("io_enable", 16'(o_io_access_enable), 16'(io));
        chk("ir_valid", 16'(o_ir_valid), 16'(vld));
        if (vld) chk("ir_data", 16'(o_ir_data), 16'(ir));
        chk("wdog", 16'(o_watchdog_disable), 16'(wdg));
    endtask

    // Predicts what the unit registered at the edge just passed
    task automatic model();
        int m, sw, inj, nb;
        m   = en && i_cpu_fetch && i_cpu_addr == 16'(ba) && !breakpoint_unit;
        sw  = i_wr_control && i_wr_data[6];
        inj = i_opcode_fetch && !breakpoint_unit && (pend || m);
        nb  = inj || (breakpoint_unit && !(i_opcode_fetch && i_fetch_data == RET_OP));
        wdg = nb && i_watchdog_test;
        req = m || sw;
        if (i_wr_control) begin
            en  = i_wr_data[7];
            act = i_wr_data[6];
        end
        if (m) act = 1;
        if (i_wr_break_address_high) ba[15:8] = i_wr_data;
        if (i_wr_break_address_low) ba[7:0] = i_wr_data;
        pend = inj ? 0 : (!breakpoint_unit && (m || sw)) ? 1 : pend;
        ir   = inj ? INT_OP : i_fetch_data;
        vld  = i_opcode_fetch;
        vec  = (i_monitor_mode ? VECTOR_MONITOR : VECTOR_NORMAL) + (i_vector_low ? 1 : 0);
        breakpoint_unit  = nb;
        io   = 1;
    endtask

    task automatic tick();
        @(posedge i_mclk);
        #1;
        model();
        cmp();
    endtask

    // Each transfer sets every strobe once, so nothing changes twice in one step
    task automatic nop();
        {i_wr_break_address_high, i_wr_break_address_low, i_wr_control} = 3'b000;
        cpu.release_bus();
        tick();
    endtask

    task automatic wr(input int k, input logic [7:0] d);
        i_wr_data = d;
        {i_wr_break_address_high, i_wr_break_address_low, i_wr_control} = 3'(3'b100 >> k);
        cpu.release_bus();
        tick();
    endtask

    task automatic fe(input logic [15:0] a, input logic f, input logic op, input logic [7:0] d);
        {i_wr_break_address_high, i_wr_break_address_low, i_wr_control} = 3'b000;
        cpu.drive(a, f, op, d);
        tick();
    endtask

    task automatic do_reset();
        i_rst = 1'b1;
        i_watchdog_test = 1'b0;
        {i_wr_break_address_high, i_wr_break_address_low, i_wr_control} = 3'b000;
        repeat (6) @(posedge i_mclk);
        #1;
        en   = 0;
        act  = 0;
        breakpoint_unit  = 0;
        pend = 0;
        req  = 0;
        vld  = 0;
        io   = 0;
        wdg  = 0;
        ba   = 0;
        vec = VECTOR_NORMAL;
        cmp();
        i_rst = 1'b0;
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        #3_000_000;
        err_total++;
        summarize();
    end

    initial begin
        seed = 11;
        err_total = 0;
        n_compared = 0;
        {i_vector_low, i_monitor_mode} = 2'b00;
        i_wr_data = 8'h00;
        do_reset();
        t = 16'($random(seed));
        wr(0, t[15:8]);
        wr(1, t[7:0]);
        wr(2, 8'h80);
        fe(t, 1'b1, 1'b1, 8'h5a);
        for (int k = 0; k < 4; k++) begin
            {i_monitor_mode, i_vector_low} = 2'(k);
            nop();
        end
        fe(16'(t + 1), 1'b1, 1'b1, RET_OP);
        wr(2, 8'h80);
        $display("test opcode break done");
        fe(t, 1'b0, 1'b0, 8'h33);
        wr(2, 8'h00);
        fe(t, 1'b1, 1'b1, 8'h44);
        wr(2, 8'h80);
        $display("test no break cases done");
        i_watchdog_test = 1'b1;
        fe(t, 1'b1, 1'b0, 8'h10);
        fe(16'(t + 1), 1'b1, 1'b1, 8'h20);
        repeat (3) nop();
        fe(16'(t + 2), 1'b1, 1'b1, RET_OP);
        i_watchdog_test = 1'b0;
        wr(2, 8'h80);
        $display("test operand break done");
        wr(2, 8'hc0);
        nop();
        fe(16'(t + 3), 1'b1, 1'b1, 8'h66);
        wr(2, 8'hc0);
        fe(16'(t + 4), 1'b1, 1'b1, RET_OP);
        wr(2, 8'h80);
        $display("test software break done");
        repeat (600) begin
            r = $random(seed);
            {i_monitor_mode, i_vector_low, i_watchdog_test} = r[2:0];
            if (r[7:3] == 5'h00) wr(2, r[15:8]);
            else fe(r[3] ? t : r[31:16], r[4], r[5], r[6] ? RET_OP : r[15:8]);
        end
        $display("test random traffic done");
        wr(0, 8'ha5);
        wr(2, 8'hc0);
        do_reset();
        nop();
        $display("test second reset done");
        summarize();
    end
endmodule

/* address_compare_if.sv */
// Carrier between the breakpoint control and its address comparator.
// Assumes both ends share one clock and reset.
`timescale 1ns/1ps
interface address_compare_if;
    logic        clk;
    logic        rst;
    logic [15:0] cpu_addr;
    logic        cpu_fetch;
    logic [15:0] break_addr;
    logic        enable;
    logic        blocked;
    logic        match;

    modport ctrl (
        output clk, rst, cpu_addr, cpu_fetch, break_addr, enable, blocked,
        input  match
    );
    modport cmp (
        input  clk, rst, cpu_addr, cpu_fetch, break_addr, enable, blocked,
        output match
    );
endinterface

/* address_match_unit.sv */
// Full-width program address comparator for the breakpoint unit.
// Assumes the fetch qualifier is high only for program counter accesses.
`timescale 1ns/1ps
module address_match_unit (
    address_compare_if.cmp bus
);
    wire addr_equal;

    assign addr_equal = (bus.cpu_addr == bus.break_addr);
    // Data accesses never qualify, so only program fetches can break
    assign bus.match  = bus.enable && bus.cpu_fetch && !bus.blocked && addr_equal;

    a_match_exact: assert property (@(posedge bus.clk) disable iff (bus.rst)
        bus.match |-> (bus.cpu_addr == bus.break_addr) && bus.enable)
        else $error("match without full address equality");
    a_fetch_only: assert property (@(posedge bus.clk) disable iff (bus.rst)
        !bus.cpu_fetch |-> !bus.match)
        else $error("match on a non-fetch access");
endmodule

/* breakpoint_pkg.sv */
// Shared constants for the address breakpoint unit.
// Assumes an 8-bit data path and a 16-bit program address bus.
package breakpoint_pkg;
    localparam int          ADDR_W            = 16;
    localparam int          DATA_W            = 8;
    localparam int          ENABLE_FLAG_BIT   = 7;
    localparam int          ACTIVE_FLAG_BIT   = 6;
    localparam logic [7:0]  ADDR_BYTE_RESET   = 8'h00;
    localparam logic        FLAG_RESET        = 1'b0;
    localparam logic [15:0] VECTOR_NORMAL     = 16'hfffc;
    localparam logic [15:0] VECTOR_MONITOR    = 16'hfefc;
    localparam logic [15:0] VECTOR_LOW_OFFSET = 16'h0001;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PENDING,
        ST_BREAK
    } break_state_e;
endpackage

/* cpu_fetch_model.sv */
// Behavioural CPU bus model that feeds fetch cycles to the breakpoint unit.
// Assumes the bench calls drive() and release_bus() just after a rising edge.
`timescale 1ns/1ps
module cpu_fetch_model (
    // CPU bus toward the block
    output logic [15:0] o_addr,
    output logic        o_fetch,
    output logic        o_opcode,
    output logic [7:0]  o_data
);
    initial begin
        o_addr   = 16'h0000;
        o_fetch  = 1'b0;
        o_opcode = 1'b0;
        o_data   = 8'h00;
    end
    // An opcode fetch is always a program fetch as well
    task automatic drive(input logic [15:0] a, input logic f, input logic op,
                         input logic [7:0] d);
        o_addr   = a;
        o_fetch  = f | op;
        o_opcode = op;
        o_data   = d;
    endtask
    // Released bus shows no stale value, so a held address cannot fake a match
    task automatic release_bus();
        o_addr   = ~o_addr;
        o_data   = ~o_data;
        o_fetch  = 1'b0;
        o_opcode = 1'b0;
    endtask
endmodule
